// ==== core/acs_device.sv ====
/*
  Conversion sequencer: start, timing, completion, sleep handling and
  auto-trigger selection around a 10-bit successive-approximation core.
  Assumes the controller on the link drives the control bits and that
  sample_in holds the settled code of the converter core.
*/
// Operation
// R01 - completion clears active, sets done, loads result
// R02 - reset clears state, aborts conversion
// R03 - runs in sleep only on rc clock
// R04 - rc clock delays start one instruction
// R05 - sleep completion with irq enabled wakes
// R06 - sleep completion without irq powers down
// R07 - sleep on other clock aborts, powers down
// R08 - trigger rising edge sets active flag
// R09 - five-bit field selects trigger source
// R10 - code zero off, one selects pin
// R11 - codes two to four select timers
// R12 - codes five to eighteen other sources
// R13 - software avoids reserved trigger codes
// R14 - triggers ignored during sleep
// R15 - software keeps trigger timing legal
// R16 - software follows the conversion procedure order
// R17 - software clears done flag after reading
// R18 - software waits acquisition after channel change
// R19 - clock codes 011 and 111 select rc
// R20 - justify select shapes result halves
// R21 - writing active starts, reads one meanwhile
// R22 - never start in enabling write
// R23 - triggers during conversion are ignored
// R24 - each trigger synchronised, one pulse per edge
`timescale 1ns/10ps
module acs_device (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // controller link
  acs_if.device link,
  // trigger sources, bit n is code n+1
  input wire logic [acs_pkg::TRIG_SOURCES-1:0] trigger_sources_in,
  // converter core
  input wire logic [acs_pkg::RESULT_BITS-1:0] sample_in,
  output logic analog_power_out,
  output logic sampling_out
);
  import acs_pkg::*;

  // ************************************************************
  // types and declarations
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DELAY = 3'b010,
    ST_CONVERT = 3'b100
  } acs_state_t;

  acs_state_t state;
  acs_state_t next_state;
  logic [TRIG_SOURCES-1:0] source_rise;
  logic trigger_rise;
  logic rc_clock;
  logic start_soft;
  logic start_auto;
  logic start_any;
  logic abort;
  logic finish;
  logic powered_down;
  logic [6:0] tad_count;
  logic [3:0] tad_left;
  logic [2:0] delay_count;
  logic [6:0] tad_length;
  logic [9:0] result_code;

  // ************************************************************
  // trigger synchronisation and selection
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < TRIG_SOURCES; i = i + 1) begin : g_sync
      acs_edge_sync u_sync (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .level_in(trigger_sources_in[i]),
        .rise_out(source_rise[i])
      );
    end
  endgenerate

  // edges are muxed, not levels, so a source change cannot fake an edge
  always_comb begin
    trigger_rise = 1'b0;
    if (link.trigger_source_select != TRIG_OFF && link.trigger_source_select <= TRIG_LAST) begin // R09 R10 R11 R12
      trigger_rise = source_rise[link.trigger_source_select - 5'h01];
    end
  end

  // ************************************************************
  // start and abort conditions
  // ************************************************************
  assign rc_clock = (link.conversion_clock_select[1:0] == CLK_RC_LOW); // R19
  assign start_soft = link.start_request && link.converter_enable && !powered_down; // R21
  assign start_auto = trigger_rise && link.converter_enable && !link.sleep_active && !powered_down; // R08 R14
  assign start_any = (state == ST_IDLE) && (start_soft || start_auto); // R23
  assign abort = !link.converter_enable || powered_down || (link.sleep_active && !rc_clock); // R03 R07
  assign finish = (state == ST_CONVERT) && !abort && (tad_count == 7'h00) && (tad_left == 4'h0);

  always_comb begin
    unique case (link.conversion_clock_select)
      CLK_DIV2: tad_length = 7'h02;
      CLK_DIV4: tad_length = 7'h04;
      CLK_DIV8: tad_length = 7'h08;
      CLK_DIV16: tad_length = 7'h10;
      CLK_DIV32: tad_length = 7'h20;
      CLK_DIV64: tad_length = 7'h40;
      default: tad_length = 7'(FRC_TAD_CYCLES);
    endcase
  end

  // ************************************************************
  // sequence state
  // ************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_any) begin
          next_state = rc_clock ? ST_DELAY : ST_CONVERT; // R04
        end
      end
      ST_DELAY: begin
        if (abort) begin
          next_state = ST_IDLE;
        end else if (delay_count == 3'h0) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (abort || finish) begin
          next_state = ST_IDLE; // R01 R07
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= ST_IDLE; // R02
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // delay and conversion counters
  // ************************************************************
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      delay_count <= 3'h0;
      tad_count <= 7'h00;
      tad_left <= 4'h0;
    end else begin
      if (start_any) begin
        delay_count <= 3'(INSTR_CYCLES - 1); // R04
      end else if (state == ST_DELAY && delay_count != 3'h0) begin
        delay_count <= delay_count - 3'h1;
      end
      if (next_state == ST_CONVERT && state != ST_CONVERT) begin
        tad_count <= tad_length - 7'h01;
        tad_left <= 4'(CONV_TADS - 1);
      end else if (state == ST_CONVERT) begin
        if (tad_count == 7'h00) begin
          tad_count <= tad_length - 7'h01;
          tad_left <= tad_left - 4'h1;
        end else begin
          tad_count <= tad_count - 7'h01;
        end
      end
    end
  end

  // ************************************************************
  // completion: flags and result
  // ************************************************************
  assign result_code = sample_in;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      link.conversion_done_flag <= 1'b0;
    end else if (finish) begin
      link.conversion_done_flag <= 1'b1; // R01
    end else if (link.done_clear) begin
      link.conversion_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      link.result_high <= 8'h00;
      link.result_low <= 8'h00;
    end else if (finish) begin
      if (link.result_justify_select) begin
        link.result_high <= {6'h00, result_code[9:8]}; // R20
        link.result_low <= result_code[7:0]; // R01
      end else begin
        link.result_high <= result_code[9:2]; // R20
        link.result_low <= {result_code[1:0], 6'h00}; // R01
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      link.conversion_active_flag <= 1'b0;
    end else begin
      link.conversion_active_flag <= (next_state != ST_IDLE); // R01 R21
    end
  end

  // ************************************************************
  // sleep and power
  // ************************************************************
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      powered_down <= 1'b0;
      link.wake_request <= 1'b0;
    end else begin
      link.wake_request <= finish && link.sleep_active && link.conversion_irq_enable; // R05
      if (!link.sleep_active) begin
        powered_down <= 1'b0;
      end else if (link.converter_enable && !rc_clock) begin
        powered_down <= 1'b1; // R07
      end else if (finish && !link.conversion_irq_enable) begin
        powered_down <= 1'b1; // R06
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      analog_power_out <= 1'b0; // R02
      sampling_out <= 1'b0;
      link.converter_powered <= 1'b0;
    end else begin
      analog_power_out <= link.converter_enable && !powered_down; // R06
      link.converter_powered <= link.converter_enable && !powered_down;
      sampling_out <= link.converter_enable && !powered_down && (state == ST_IDLE);
    end
  end
endmodule

// ==== core/acs_pkg.sv ====
/*
  Shared constants for the conversion sequencer: register map of the
  controller, field positions, clock-select and trigger-source codes,
  conversion timing counts.
  Assumes a single 100 MHz system clock shared by both ends.
*/
package acs_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int INSTR_PERIOD_NS = 40;
  localparam int INSTR_CYCLES = (INSTR_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CONV_TADS = 12;
  localparam int FRC_TAD_CYCLES = 16;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int RESULT_BITS = 10;
  localparam int TRIG_SOURCES = 18;
  localparam int TRIG_BITS = 5;
  localparam int CLKSEL_BITS = 3;

  // ************************************************************
  // clock select codes
  // ************************************************************
  localparam logic [2:0] CLK_DIV2 = 3'h0;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV4 = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [1:0] CLK_RC_LOW = 2'h3;

  // ************************************************************
  // trigger source codes
  // ************************************************************
  localparam logic [4:0] TRIG_OFF = 5'h00;
  localparam logic [4:0] TRIG_PIN = 5'h01;
  localparam logic [4:0] TRIG_TIMER_ZERO = 5'h02;
  localparam logic [4:0] TRIG_TIMER_ONE = 5'h03;
  localparam logic [4:0] TRIG_TIMER_TWO = 5'h04;
  localparam logic [4:0] TRIG_CAPTURE_A = 5'h05;
  localparam logic [4:0] TRIG_WAVE_A = 5'h07;
  localparam logic [4:0] TRIG_NUM_OSC = 5'h0b;
  localparam logic [4:0] TRIG_COMP_A = 5'h0c;
  localparam logic [4:0] TRIG_PIN_CHANGE = 5'h0e;
  localparam logic [4:0] TRIG_LOGIC_A = 5'h0f;
  localparam logic [4:0] TRIG_LAST = 5'h12;

  // ************************************************************
  // controller register map (byte addresses)
  // ************************************************************
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_TRIGGER = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RESULT = 4'hc;

  // control fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_ACTIVE = 1;
  localparam int CTL_IRQ_ENABLE = 2;
  localparam int CTL_JUSTIFY = 3;
  localparam int CTL_CLKSEL = 4;
  localparam int CTL_SLEEP = 7;
  // status fields
  localparam int STS_DONE = 0;
  localparam int STS_POWERED = 1;
  // reset values
  localparam logic [2:0] CLKSEL_RESET = 3'h0;
  localparam logic [4:0] TRIG_RESET = 5'h00;

endpackage

// ==== core/acs_if.sv ====
/*
  Link between the conversion sequencer and its controller.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface acs_if;
  // controller to sequencer
  logic converter_enable;
  logic start_request;
  logic done_clear;
  logic conversion_irq_enable;
  logic result_justify_select;
  logic [2:0] conversion_clock_select;
  logic [4:0] trigger_source_select;
  logic sleep_active;
  // sequencer to controller
  logic conversion_active_flag;
  logic conversion_done_flag;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic wake_request;
  logic converter_powered;

  modport device (
    input converter_enable, start_request, done_clear, conversion_irq_enable,
    input result_justify_select, conversion_clock_select, trigger_source_select, sleep_active,
    output conversion_active_flag, conversion_done_flag, result_high, result_low,
    output wake_request, converter_powered
  );

  modport host (
    output converter_enable, start_request, done_clear, conversion_irq_enable,
    output result_justify_select, conversion_clock_select, trigger_source_select, sleep_active,
    input conversion_active_flag, conversion_done_flag, result_high, result_low,
    input wake_request, converter_powered
  );
endinterface

// ==== core/acs_edge_sync.sv ====
/*
  Three-flop synchroniser with agreement filter and rising-edge pulse.
  Assumes level_in is asynchronous to clock_in.
*/
`timescale 1ns/10ps
module acs_edge_sync (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // signal
  input wire logic level_in,
  output logic rise_out
);
  logic stage_a;
  logic stage_b;
  logic stage_c;
  logic stable;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      stage_a <= 1'b0;
      stage_b <= 1'b0;
      stage_c <= 1'b0;
    end else begin
      stage_a <= level_in;
      stage_b <= stage_a;
      stage_c <= stage_b;
    end
  end

  // level counts once second and third stage agree
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      stable <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      if (stage_b == stage_c) begin
        stable <= stage_c;
      end
      rise_out <= (stage_b == stage_c) && stage_c && !stable; // R24
    end
  end
endmodule

// ==== core/acs_host.sv ====
/*
  Controller end: Avalon-MM slave with waitrequest holding the control,
  trigger, status and result registers, driving the sequencer link.
  Assumes a master that holds each request until waitrequest is low.
*/
`timescale 1ns/10ps
module acs_host (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // avalon-mm slave
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // sequencer link
  acs_if.host link
);
  import acs_pkg::*;

  // ************************************************************
  // bus handshake
  // ************************************************************
  logic ack;
  logic write_now;

  // one wait cycle per access; the access acts on the ack cycle
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ack <= 1'b0;
    end else begin
      ack <= (read_in || write_in) && !ack;
    end
  end

  assign waitrequest_out = (read_in || write_in) && !ack;
  assign write_now = write_in && ack;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      readdata_out <= 32'h00000000;
    end else if (read_in && !ack) begin
      unique case (address_in)
        REG_CONTROL: readdata_out <= {24'h000000, link.sleep_active, link.conversion_clock_select,
                                      link.result_justify_select, link.conversion_irq_enable,
                                      link.conversion_active_flag, link.converter_enable};
        REG_TRIGGER: readdata_out <= {27'h0000000, link.trigger_source_select};
        REG_STATUS: readdata_out <= {30'h00000000, link.converter_powered, link.conversion_done_flag};
        REG_RESULT: readdata_out <= {16'h0000, link.result_high, link.result_low};
        default: readdata_out <= 32'h00000000;
      endcase
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      link.converter_enable <= 1'b0;
      link.conversion_irq_enable <= 1'b0;
      link.result_justify_select <= 1'b0;
      link.conversion_clock_select <= CLKSEL_RESET;
    end else if (write_now && address_in == REG_CONTROL) begin
      link.converter_enable <= writedata_in[CTL_ENABLE];
      link.conversion_irq_enable <= writedata_in[CTL_IRQ_ENABLE];
      link.result_justify_select <= writedata_in[CTL_JUSTIFY];
      link.conversion_clock_select <= writedata_in[CTL_CLKSEL +: CLKSEL_BITS];
    end
  end

  // wake from a completed conversion ends sleep; a write setting sleep wins
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      link.sleep_active <= 1'b0;
    end else if (write_now && address_in == REG_CONTROL) begin
      link.sleep_active <= writedata_in[CTL_SLEEP];
    end else if (link.wake_request) begin
      link.sleep_active <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      link.trigger_source_select <= TRIG_RESET;
    end else if (write_now && address_in == REG_TRIGGER && writedata_in[4:0] <= TRIG_LAST) begin
      link.trigger_source_select <= writedata_in[4:0]; // R13
    end
  end

  // ************************************************************
  // one-cycle orders
  // ************************************************************
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      link.start_request <= 1'b0;
      link.done_clear <= 1'b0;
    end else begin
      link.start_request <= write_now && address_in == REG_CONTROL && writedata_in[CTL_ACTIVE]
                            && writedata_in[CTL_ENABLE] && link.converter_enable; // R22 R16
      link.done_clear <= write_now && address_in == REG_STATUS && writedata_in[STS_DONE]; // R17
    end
  end
endmodule

// ==== sim/acs_asserts.sv ====
/*
  Checker for the link between controller and sequencer.
  Assumes one clock and the synchronous active-high reset of both ends.
*/
`timescale 1ns/10ps
module acs_asserts (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // controller to sequencer
  input wire logic converter_enable,
  input wire logic start_request,
  input wire logic done_clear,
  input wire logic conversion_irq_enable,
  input wire logic result_justify_select,
  input wire logic [2:0] conversion_clock_select,
  input wire logic [4:0] trigger_source_select,
  input wire logic sleep_active,
  // sequencer to controller
  input wire logic conversion_active_flag,
  input wire logic conversion_done_flag,
  input wire logic [7:0] result_high,
  input wire logic [7:0] result_low,
  input wire logic wake_request,
  input wire logic converter_powered
);
  import acs_pkg::*;
  // ************************************************************
  // helpers
  // ************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic [9:0] act_cnt;
  logic [9:0] conv_len;
  logic rc_sel;
  assign rc_sel = (conversion_clock_select[1:0] == 2'h3);
  always_comb begin
    case (conversion_clock_select)
      3'h0: conv_len = 10'h018;
      3'h1: conv_len = 10'h060;
      3'h2: conv_len = 10'h180;
      3'h4: conv_len = 10'h030;
      3'h5: conv_len = 10'h0c0;
      3'h6: conv_len = 10'h300;
      default: conv_len = 10'h0c4;
    endcase
  end
  // cycles the busy flag has been high
  always_ff @(posedge clock_in) begin
    if (reset_in || !conversion_active_flag) begin
      act_cnt <= 10'h0;
    end else begin
      act_cnt <= act_cnt + 10'h1;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  AST_DONE_END: assert property ($rose(conversion_done_flag) |-> $fell(conversion_active_flag))
    else $error("done flag rose without the end of a conversion");
  AST_CONV_LEN: assert property ($rose(conversion_done_flag) |-> act_cnt + 10'h1 >= conv_len && act_cnt <= conv_len + 10'h6)
    else $error("conversion length wrong for clock select");
  AST_RESULT_ONLY_AT_END: assert property ($changed({result_high, result_low}) |-> $fell(conversion_active_flag))
    else $error("result changed outside a completion");
  AST_RESET_CLEAR: assert property ($fell(reset_in) |-> !conversion_active_flag && !conversion_done_flag && !converter_powered && result_high == 8'h0)
    else $error("state not cleared by reset");
  AST_JUSTIFY: assert property ($rose(conversion_done_flag) |-> (result_justify_select ? result_high[7:2] == 6'h0 : result_low[5:0] == 6'h0))
    else $error("result halves not shaped by justify select");
  AST_START: assert property (start_request && converter_enable && !conversion_active_flag && !sleep_active && !rc_sel |=> conversion_active_flag)
    else $error("start request did not set busy");
  AST_SLEEP_ABORT: assert property ($rose(sleep_active) && converter_enable && !rc_sel |-> ##2 (!converter_powered && !conversion_active_flag))
    else $error("sleep on system clock did not abort");
  AST_NO_TRIG_SLEEP: assert property (sleep_active && !rc_sel && !conversion_active_flag |=> !conversion_active_flag)
    else $error("conversion started during sleep");
  AST_WAKE: assert property ($rose(conversion_done_flag) && sleep_active && conversion_irq_enable |-> wake_request)
    else $error("no wake after completion in sleep");
  AST_SLEEP_OFF: assert property ($rose(conversion_done_flag) && sleep_active && !conversion_irq_enable |-> ##[0:2] !converter_powered)
    else $error("converter still powered after completion in sleep");
  AST_DONE_HOLD: assert property (conversion_done_flag && !done_clear |=> conversion_done_flag)
    else $error("done flag lost without a clear");
  C_WAKE: cover property ($rose(wake_request));
  C_RC_DONE: cover property ($rose(conversion_done_flag) && conversion_clock_select == 3'h7);
  C_ABORT: cover property ($rose(sleep_active) && conversion_active_flag);
endmodule

// ==== sim/adc_conversion_sequencer_tb.sv ====
/*
  Testbench: host and sequencer joined by the link, driven over Avalon-MM.
  Assumes the one-wait-state slave timing of the host end.
*/
`timescale 1ns/10ps
module adc_conversion_sequencer_tb;
  import acs_pkg::*;
  logic clock_in;
  logic reset_in;
  logic [3:0] address_in;
  logic read_in;
  logic write_in;
  logic [31:0] writedata_in;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic [17:0] trigger_sources_in;
  logic [9:0] sample_in;
  logic [9:0] s;
  logic [1:0] pins;
  logic [31:0] last;
  logic [31:0] exp_q[$];
  int error_cnt;
  int n_compared;
  int seed;
  acs_if link();
  acs_host acs_host_inst (.clock_in(clock_in), .reset_in(reset_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .link(link));
  acs_device acs_device_inst (.clock_in(clock_in), .reset_in(reset_in), .link(link),
    .trigger_sources_in(trigger_sources_in), .sample_in(sample_in),
    .analog_power_out(pins[0]), .sampling_out(pins[1]));
  acs_asserts acs_asserts_inst (.clock_in(clock_in), .reset_in(reset_in),
    .converter_enable(link.converter_enable), .start_request(link.start_request),
    .done_clear(link.done_clear), .conversion_irq_enable(link.conversion_irq_enable),
    .result_justify_select(link.result_justify_select), .conversion_clock_select(link.conversion_clock_select),
    .trigger_source_select(link.trigger_source_select), .sleep_active(link.sleep_active),
    .conversion_active_flag(link.conversion_active_flag), .conversion_done_flag(link.conversion_done_flag),
    .result_high(link.result_high), .result_low(link.result_low),
    .wake_request(link.wake_request), .converter_powered(link.converter_powered));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", name, e, g);
      error_cnt++;
    end
  endtask
  // one access; a tracked read notes its expected data first
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, input logic t,
                     output logic [31:0] q);
    int n;
    @(posedge clock_in);
    if (t) begin
      exp_q.push_back(d);
    end
    address_in <= a;
    read_in <= !w;
    write_in <= w;
    writedata_in <= w ? d : 32'h0;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 20);
    q = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, e, 1'b1, q);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, 1'b0, q);
  endtask
  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(REG_CONTROL, 1'b0, 32'h0, 1'b0, q);
      n++;
    end while (q[1] !== 1'b0 && n < 500);
    if (n >= 500) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic samp();
    s = 10'($random(seed));
    sample_in <= s;
  endtask
  function automatic logic [31:0] res(input logic [9:0] v, input logic j);
    return j ? {22'h0, v} : {16'h0, v, 6'h0};
  endfunction
  // ************************************************************
  // checking and stimulus
  // ************************************************************
  always @(posedge clock_in) begin
    if (read_in === 1'b1 && waitrequest_out === 1'b0 && exp_q.size() > 0) begin
      if (address_in == REG_STATUS) begin
        cmp("pins", {30'h0, {2{exp_q[0][1]}}}, {30'h0, pins});
      end
      cmp("readdata", exp_q.pop_front(), readdata_out);
    end
  end
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    logic [7:0] ctl;
    reset_in = 1'b1;
    address_in = 4'h0;
    read_in = 1'b0;
    write_in = 1'b0;
    writedata_in = 32'h0;
    trigger_sources_in = 18'h0;
    sample_in = 10'h0;
    seed = 46973;
    error_cnt = 0;
    n_compared = 0;
    repeat (10) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(REG_CONTROL, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(REG_RESULT, 32'h0);
    rd(4'h2, 32'h0);
    wr(REG_CONTROL, 32'h3);
    rd(REG_CONTROL, 32'h1);
    for (int i = 0; i < 8; i++) begin
      ctl = {1'b0, 3'(i), 1'(i), 1'b0, 2'h3};
      samp();
      wr(REG_CONTROL, {24'h0, ctl});
      wait_idle();
      last = res(s, ctl[3]);
      rd(REG_RESULT, last);
      rd(REG_STATUS, 32'h3);
      rd(REG_CONTROL, {24'h0, ctl & 8'hfd});
      wr(REG_STATUS, 32'h1);
    end
    wr(REG_CONTROL, 32'h1);
    for (int c = 0; c <= 18; c++) begin
      samp();
      wr(REG_TRIGGER, 32'(c));
      trigger_sources_in <= (c == 0) ? 18'h3ffff : ~(18'h1 << (c - 1));
      repeat (8) @(posedge clock_in);
      rd(REG_STATUS, 32'h2);
      if (c > 0) begin
        trigger_sources_in <= 18'h3ffff;
        repeat (8) @(posedge clock_in);
        wait_idle();
        last = res(s, 1'b0);
        rd(REG_RESULT, last);
        rd(REG_STATUS, 32'h3);
        wr(REG_STATUS, 32'h1);
      end
      trigger_sources_in <= 18'h0;
      repeat (8) @(posedge clock_in);
    end
    wr(REG_TRIGGER, 32'h13);
    rd(REG_TRIGGER, 32'h12);
    wr(REG_TRIGGER, 32'h1);
    samp();
    wr(REG_CONTROL, 32'h63);
    wr(REG_CONTROL, 32'he1);
    trigger_sources_in <= 18'h1;
    repeat (8) @(posedge clock_in);
    rd(REG_CONTROL, 32'he1);
    rd(REG_STATUS, 32'h0);
    trigger_sources_in <= 18'h0;
    wr(REG_CONTROL, 32'h61);
    rd(REG_RESULT, last);
    rd(REG_STATUS, 32'h2);
    samp();
    wr(REG_CONTROL, 32'h37);
    wr(REG_CONTROL, 32'hb5);
    wait_idle();
    last = res(s, 1'b0);
    rd(REG_CONTROL, 32'h35);
    rd(REG_STATUS, 32'h3);
    rd(REG_RESULT, last);
    wr(REG_STATUS, 32'h1);
    samp();
    wr(REG_CONTROL, 32'h33);
    wr(REG_CONTROL, 32'hb1);
    wait_idle();
    last = res(s, 1'b0);
    rd(REG_STATUS, 32'h1);
    rd(REG_CONTROL, 32'hb1);
    wr(REG_CONTROL, 32'h31);
    rd(REG_RESULT, last);
    rd(REG_STATUS, 32'h3);
    samp();
    wr(REG_CONTROL, 32'h63);
    reset_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(REG_CONTROL, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(REG_RESULT, 32'h0);
    wrap_up();
  end
endmodule
